// file: accumulator_extract_and_byte_extend_test.sv
// Self-checking bench for the accumulator extract and byte extend datapath.
// Assumes the sequencer model drives the register bus one access at a time.
`timescale 1ns/10ps
`default_nettype none
`include "aebx_defs.svh"

module accumulator_extract_and_byte_extend_test;
  typedef struct {
    logic [7:0] a0x;
    logic [31:0] a0w;
    logic [7:0] a1x;
    logic [31:0] a1w;
    logic [31:0] src;
    logic [5:0] st;
    logic [9:0] cmd;
    logic [31:0] dest;
    logic [5:0] exp_st;
  } aebx_row_s;

  // ****************************************************************
  // Stimulus table
  // ****************************************************************
  // Each row presets the destination to 32'hAAAA5555 so untouched halves are visible.
  aebx_row_s rows [24] = '{
    '{8'h00,32'h12348000,8'h00,32'h12358000,32'h0,6'h00,10'h301,32'h12361234,6'h00},
    '{8'h00,32'h12348000,8'h00,32'h0,32'h0,6'h20,10'h101,32'hAAAA1235,6'h20},
    '{8'h01,32'h0,8'h00,32'h0,32'h0,6'h00,10'h101,32'hAAAA7FFF,6'h18},
    '{8'h00,32'h0,8'hFE,32'h0,32'h0,6'h00,10'h201,32'h80005555,6'h1A},
    '{8'h00,32'h7FFF8000,8'h00,32'h0,32'h0,6'h20,10'h101,32'hAAAA7FFF,6'h38},
    '{8'h00,32'hFFFF8000,8'h00,32'h0,32'h0,6'h00,10'h111,32'hAAAAFFFF,6'h18},
    '{8'h00,32'h00001234,8'hFF,32'hFFFF8000,32'h0,6'h20,10'h321,32'h80001234,6'h22},
    '{8'h00,32'h00010000,8'h00,32'h0,32'h0,6'h00,10'h121,32'hAAAA7FFF,6'h18},
    '{8'hFF,32'hFFFFFFFF,8'h00,32'h0,32'h0,6'h00,10'h131,32'hAAAA0000,6'h19},
    '{8'h00,32'h0000FFFF,8'h00,32'h0,32'h0,6'h00,10'h131,32'hAAAAFFFF,6'h00},
    '{8'h00,32'h1234FFFF,8'h00,32'h0,32'h0,6'h20,10'h141,32'hAAAA1234,6'h20},
    '{8'h00,32'h10004000,8'h00,32'h0,32'h0,6'h20,10'h151,32'hAAAA2001,6'h20},
    '{8'h00,32'h00004000,8'h00,32'h0,32'h0,6'h00,10'h161,32'hAAAA7FFF,6'h18},
    '{8'h00,32'h12348000,8'h00,32'h0,32'h0,6'h20,10'h171,32'hAAAA1235,6'h20},
    '{8'h00,32'h0,8'h00,32'h0,32'h0,6'h14,10'h101,32'hAAAA0000,6'h15},
    '{8'h00,32'h0,8'h00,32'h0,32'h12345680,6'h3E,10'h002,32'h00000080,6'h30},
    '{8'h00,32'h0,8'h00,32'h0,32'hFFFFFF00,6'h0E,10'h002,32'h00000000,6'h01},
    '{8'h00,32'h0,8'h00,32'h0,32'h00000080,6'h3D,10'h003,32'hFFFFFF80,6'h32},
    '{8'h00,32'h0,8'h00,32'h0,32'h1234567F,6'h02,10'h003,32'h0000007F,6'h00},
    '{8'h00,32'h0,8'h00,32'h0,32'hABCDEF00,6'h1A,10'h003,32'h00000000,6'h11},
    '{8'hFF,32'hFFFF0000,8'h00,32'h00005678,32'h0,6'h00,10'h321,32'h56788000,6'h1A},
    '{8'h00,32'h56780000,8'hFF,32'hFFFF0000,32'h0,6'h20,10'h301,32'hFFFF5678,6'h22},
    '{8'h01,32'h0,8'h00,32'h0,32'h0,6'h1F,10'h000,32'hAAAA5555,6'h1F},
    '{8'h01,32'h0,8'h00,32'h0,32'h0,6'h00,10'h001,32'hAAAA5555,6'h00}
  };

  logic clk_i;
  logic rst_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic [31:0] dest_o;
  logic [5:0] status_o;
  int mismatches = 0;
  int num_checks = 0;

  aebx_core #(.ADDR_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .dest_o(dest_o),
    .status_o(status_o));

  aebx_seq_model seq (.clk_i(clk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat),
    .wb_ack_i(wb_ack));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] unused;
    seq.access(1'b1, adr, sel, dat, unused);
  endtask

  task automatic rd_check(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    seq.access(1'b0, adr, 4'hF, 32'h00000000, got);
    check(name, got, exp);
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, watchdog and main sequence
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // The table needs under two thousand cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end

  initial begin
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr(`AEBX_OFS_ACC0_WORD, rows[i].a0w, 4'hF);
      wr(`AEBX_OFS_ACC0_EXT, {24'h000000, rows[i].a0x}, 4'hF);
      wr(`AEBX_OFS_ACC1_WORD, rows[i].a1w, 4'hF);
      wr(`AEBX_OFS_ACC1_EXT, {24'h000000, rows[i].a1x}, 4'hF);
      wr(`AEBX_OFS_SRC, rows[i].src, 4'hF);
      wr(`AEBX_OFS_DEST, 32'hAAAA5555, 4'hF);
      wr(`AEBX_OFS_STATUS, {26'h0000000, rows[i].st}, 4'hF);
      wr(`AEBX_OFS_CMD, {22'h000000, rows[i].cmd}, 4'hF);
      rd_check("acc0 word", `AEBX_OFS_ACC0_WORD, rows[i].a0w);
      rd_check("acc0 ext", `AEBX_OFS_ACC0_EXT, {24'h000000, rows[i].a0x});
      rd_check("acc1 word", `AEBX_OFS_ACC1_WORD, rows[i].a1w);
      check("dest", dest_o, rows[i].dest);
      check("status", {26'h0000000, status_o}, {26'h0000000, rows[i].exp_st});
    end
    // A command whose low byte lane is off must not run; the one with lanes 0 and 1 on right after must.
    wr(`AEBX_OFS_CMD, 32'h00000101, 4'h2);
    rd_check("dest after partial command", `AEBX_OFS_DEST, 32'hAAAA5555);
    check("status after partial command", {26'h0000000, status_o}, 32'h00000000);
    wr(`AEBX_OFS_CMD, 32'h00000101, 4'h3);
    rd_check("dest after command", `AEBX_OFS_DEST, 32'hAAAA7FFF);
    check("status after command", {26'h0000000, status_o}, 32'h00000018);
    wr(`AEBX_OFS_STATUS, 32'hFFFFFFFF, 4'hF);
    rd_check("status width", `AEBX_OFS_STATUS, 32'h0000003F);
    wr(`AEBX_OFS_ACC1_EXT, 32'hFFFFFFFF, 4'hF);
    rd_check("ext width", `AEBX_OFS_ACC1_EXT, 32'h000000FF);
    wr(8'h20, 32'h12345678, 4'hF);
    rd_check("unmapped", 8'h20, 32'h00000000);
    rd_check("acc1 ext kept", `AEBX_OFS_ACC1_EXT, 32'h000000FF);
    rd_check("command reads", `AEBX_OFS_CMD, 32'h00000000);
    // A second reset in mid-run must clear the accumulators, destination and flags.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_check("acc1 ext reset", `AEBX_OFS_ACC1_EXT, 32'h00000000);
    rd_check("acc0 word reset", `AEBX_OFS_ACC0_WORD, 32'h00000000);
    check("dest reset", dest_o, 32'h00000000);
    check("status reset", {26'h0000000, status_o}, 32'h00000000);
    finish_test();
  end
endmodule // accumulator_extract_and_byte_extend_test

`default_nettype wire

// file: aebx_core.sv
// Accumulator extract and byte extend datapath with a classic Wishbone slave.
// Assumes a single 50 MHz clock and a master that holds each request until ack.
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "aebx_defs.svh"

module aebx_core #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Architectural state seen by the core.
  output logic [31:0] dest_o,
  output logic [5:0] status_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Returns the saturation indication above the 16-bit result.
  function automatic logic [16:0] extract(input aebx_pkg::aebx_acc_s acc,
                                          input aebx_pkg::aebx_opt_e opt,
                                          input logic biased);
    logic signed [41:0] s;
    logic signed [41:0] r;
    logic signed [41:0] v;
    logic uns;
    logic rnd;
    logic frac;
    logic sat;
    logic [15:0] res;
    uns = (opt == aebx_pkg::OPT_UNSIGNED_FRACTION) || (opt == aebx_pkg::OPT_UNSIGNED_INTEGER);
    rnd = (opt == aebx_pkg::OPT_DEFAULT) || (opt == aebx_pkg::OPT_UNSIGNED_FRACTION) ||
          (opt == aebx_pkg::OPT_SCALED_ROUND) || (opt == aebx_pkg::OPT_HIGH_WORD_INTEGER);
    frac = rnd || (opt == aebx_pkg::OPT_TRUNCATE);
    // The unsigned fraction view reads all 40 bits as magnitude.
    if (opt == aebx_pkg::OPT_UNSIGNED_FRACTION) begin
      s = {2'h0, acc.ext, acc.word};
    end else begin
      s = {{2{acc.ext[7]}}, acc.ext, acc.word};
    end
    if ((opt == aebx_pkg::OPT_SCALED_ROUND) || (opt == aebx_pkg::OPT_SCALED_INTEGER)) begin
      s = s <<< 1;
    end
    r = s;
    if (rnd) begin
      r = s + `AEBX_ROUND_HALF;
      // Unbiased rounding sends an exact half to the even neighbour.
      if (!biased && (s[15:0] == 16'h8000)) begin
        r[16] = 1'b0;
      end
    end
    // Integer options other than the high word one keep the whole value so that saturation sees every bit.
    v = frac ? (r >>> 16) : s;
    sat = 1'b0;
    res = v[15:0];
    if (uns) begin
      if (v < 42'sh0) begin
        sat = 1'b1;
        res = 16'h0000;
      end else if (v > `AEBX_UMAX) begin
        sat = 1'b1;
        res = 16'hFFFF;
      end
    end else begin
      if (v > `AEBX_SMAX) begin
        sat = 1'b1;
        res = 16'h7FFF;
      end else if (v < `AEBX_SMIN) begin
        sat = 1'b1;
        res = 16'h8000;
      end
    end
    return {sat, res};
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************

  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic req;
  logic wr_now;
  logic [ADDR_W-1:0] adr;

  aebx_pkg::aebx_acc_s acc0_q;
  aebx_pkg::aebx_acc_s acc0_d;
  aebx_pkg::aebx_acc_s acc1_q;
  aebx_pkg::aebx_acc_s acc1_d;
  logic [31:0] src_q;
  logic [31:0] src_d;
  logic [31:0] dest_q;
  logic [31:0] dest_d;
  aebx_pkg::aebx_status_s stat_q;
  aebx_pkg::aebx_status_s stat_d;

  assign req = wb_cyc_i && wb_stb_i;
  // A write lands on the very edge at which the master samples ack.
  assign wr_now = req && wb_we_i && ack_q;
  assign adr = wb_adr_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_comb begin
    ack_d = req && !ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      unique case (adr)
        ADDR_W'(`AEBX_OFS_ACC0_WORD): rdat_d = acc0_q.word;
        ADDR_W'(`AEBX_OFS_ACC0_EXT): rdat_d = {24'h000000, acc0_q.ext};
        ADDR_W'(`AEBX_OFS_ACC1_WORD): rdat_d = acc1_q.word;
        ADDR_W'(`AEBX_OFS_ACC1_EXT): rdat_d = {24'h000000, acc1_q.ext};
        ADDR_W'(`AEBX_OFS_SRC): rdat_d = src_q;
        ADDR_W'(`AEBX_OFS_DEST): rdat_d = dest_q;
        ADDR_W'(`AEBX_OFS_STATUS): rdat_d = {26'h0000000, stat_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= `AEBX_RST_WORD;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ****************************************************************
  // Command decode and extraction
  // ****************************************************************

  logic fire;
  aebx_pkg::aebx_op_e op;
  aebx_pkg::aebx_opt_e opt;
  logic lo_en;
  logic hi_en;
  logic [16:0] ex0;
  logic [16:0] ex1;
  logic [15:0] new_lo;
  logic [15:0] new_hi;
  logic any_sat;
  logic all_zero;
  logic any_neg;
  logic signed_opt;
  logic [31:0] byte_res;

  // The command register is write-only: a write to it with byte lanes 0 and 1 on issues one operation.
  assign fire = wr_now && (adr == ADDR_W'(`AEBX_OFS_CMD)) && wb_sel_i[0] && wb_sel_i[1];
  assign op = aebx_pkg::aebx_op_e'(wb_dat_i[`AEBX_CMD_OP_LSB +: 2]);
  assign opt = aebx_pkg::aebx_opt_e'(wb_dat_i[`AEBX_CMD_OPT_LSB +: 3]);
  assign lo_en = wb_dat_i[`AEBX_CMD_LO_BIT];
  assign hi_en = wb_dat_i[`AEBX_CMD_HI_BIT];

  assign ex0 = extract(acc0_q, opt, stat_q.rounding_select);
  assign ex1 = extract(acc1_q, opt, stat_q.rounding_select);
  assign new_lo = ex0[15:0];
  assign new_hi = ex1[15:0];
  assign signed_opt = (opt != aebx_pkg::OPT_UNSIGNED_FRACTION) &&
                      (opt != aebx_pkg::OPT_UNSIGNED_INTEGER);
  // With both halves written, flags describe the pair as one result.
  assign any_sat = (lo_en && ex0[16]) || (hi_en && ex1[16]);
  assign all_zero = (!lo_en || (new_lo == 16'h0000)) && (!hi_en || (new_hi == 16'h0000));
  assign any_neg = signed_opt && ((lo_en && new_lo[15]) || (hi_en && new_hi[15]));

  always_comb begin
    if (op == aebx_pkg::OP_BYTE_SEXT) begin
      byte_res = {{24{src_q[7]}}, src_q[7:0]};
    end else begin
      byte_res = {24'h000000, src_q[7:0]};
    end
  end

  // ****************************************************************
  // Architectural registers
  // ****************************************************************

  always_comb begin
    acc0_d = acc0_q;
    acc1_d = acc1_q;
    src_d = src_q;
    dest_d = dest_q;
    stat_d = stat_q;
    // Accumulators change only by software writes, never by an extraction.
    if (wr_now) begin
      unique case (adr)
        ADDR_W'(`AEBX_OFS_ACC0_WORD): acc0_d.word = merge(acc0_q.word, wb_dat_i, wb_sel_i);
        ADDR_W'(`AEBX_OFS_ACC0_EXT): if (wb_sel_i[0]) acc0_d.ext = wb_dat_i[7:0];
        ADDR_W'(`AEBX_OFS_ACC1_WORD): acc1_d.word = merge(acc1_q.word, wb_dat_i, wb_sel_i);
        ADDR_W'(`AEBX_OFS_ACC1_EXT): if (wb_sel_i[0]) acc1_d.ext = wb_dat_i[7:0];
        ADDR_W'(`AEBX_OFS_SRC): src_d = merge(src_q, wb_dat_i, wb_sel_i);
        ADDR_W'(`AEBX_OFS_DEST): dest_d = merge(dest_q, wb_dat_i, wb_sel_i);
        ADDR_W'(`AEBX_OFS_STATUS): if (wb_sel_i[0]) stat_d = wb_dat_i[5:0];
        default: ;
      endcase
    end
    if (fire) begin
      unique case (op)
        aebx_pkg::OP_ACC_HALF: begin
          if (lo_en || hi_en) begin
            if (lo_en) begin
              dest_d[15:0] = new_lo;
            end
            if (hi_en) begin
              dest_d[31:16] = new_hi;
            end
            stat_d.saturation_flag = any_sat;
            stat_d.sticky_saturation_flag = stat_q.sticky_saturation_flag || any_sat;
            stat_d.zero_result_flag = all_zero;
            stat_d.negative_flag = any_neg;
          end
        end
        aebx_pkg::OP_BYTE_ZEXT, aebx_pkg::OP_BYTE_SEXT: begin
          dest_d = byte_res;
          stat_d.zero_result_flag = (byte_res == 32'h0000_0000);
          stat_d.negative_flag = byte_res[31];
          stat_d.carry_flag = 1'b0;
          stat_d.saturation_flag = 1'b0;
        end
        // The empty operation touches neither the destination nor any flag.
        aebx_pkg::OP_NONE: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc0_q <= {`AEBX_RST_EXT, `AEBX_RST_WORD};
      acc1_q <= {`AEBX_RST_EXT, `AEBX_RST_WORD};
      src_q <= `AEBX_RST_WORD;
      dest_q <= `AEBX_RST_WORD;
      stat_q <= `AEBX_RST_STATUS;
    end else begin
      acc0_q <= acc0_d;
      acc1_q <= acc1_d;
      src_q <= src_d;
      dest_q <= dest_d;
      stat_q <= stat_d;
    end
  end

  assign dest_o = dest_q;
  assign status_o = stat_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  a_acc_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    fire |=> (acc0_q == $past(acc0_q)) && (acc1_q == $past(acc1_q)))
    else $error("Extraction changed an accumulator.");

  a_default_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_DEFAULT) && lo_en && hi_en
    && (acc0_q.ext == 8'h00) && !acc0_q.word[31] && (acc0_q.word[15:0] == 16'h0000)
    |=> dest_q[15:0] == $past(acc0_q.word[31:16]))
    else $error("Default pair move did not take the high half.");

  a_int_low_half: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_SIGNED_INTEGER) && hi_en
    && (acc1_q.ext == 8'h00) && (acc1_q.word[31:15] == 17'h00000)
    |=> dest_q[31:16] == $past(acc1_q.word[15:0]))
    else $error("Signed integer move did not take the low half.");

  a_int_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_SIGNED_INTEGER) && lo_en
    && !acc0_q.ext[7] && (acc0_q.word[31:15] != 17'h00000)
    |=> (dest_q[15:0] == 16'h7FFF) && stat_q.saturation_flag)
    else $error("Positive overflow not clamped to the signed maximum.");

  a_sat_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && any_sat
    |=> stat_q.sticky_saturation_flag ##1 (stat_q.sticky_saturation_flag || $past(wr_now)))
    else $error("Sticky saturation flag not set by a saturating move.");

  a_flags_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_now |=> $stable(stat_q))
    else $error("Status changed without an operation or a write.");

  a_zext_result: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_BYTE_ZEXT)
    |=> (dest_q == {24'h000000, $past(src_q[7:0])}) && !stat_q.negative_flag
        && !stat_q.carry_flag && !stat_q.saturation_flag)
    else $error("Byte zero extend gave a wrong result or flags.");

  a_sext_result: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_BYTE_SEXT)
    |=> (dest_q == {{24{$past(src_q[7])}}, $past(src_q[7:0])})
        && (stat_q.negative_flag == $past(src_q[7])))
    else $error("Byte sign extend gave a wrong result or flags.");

  a_sext_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_BYTE_SEXT) && (src_q[7:0] == 8'h00)
    |=> stat_q.zero_result_flag)
    else $error("Byte sign extend of zero did not set the zero flag.");

  a_trunc_norm: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_TRUNCATE) && lo_en
    && (acc0_q.ext == 8'h00) && !acc0_q.word[31]
    |=> (dest_q[15:0] == $past(acc0_q.word[31:16])) && !stat_q.saturation_flag)
    else $error("Truncate did not drop the low bits.");

  a_zext_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_BYTE_ZEXT) && (src_q[7:0] == 8'h00)
    |=> stat_q.zero_result_flag && (dest_q == 32'h0000_0000))
    else $error("Byte zero extend of zero did not set the zero flag.");

  a_sext_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_BYTE_SEXT)
    |=> !stat_q.carry_flag && !stat_q.saturation_flag
        && (stat_q.sticky_saturation_flag == $past(stat_q.sticky_saturation_flag)))
    else $error("Byte sign extend did not clear carry and saturation.");

  a_sticky_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && stat_q.sticky_saturation_flag |=> stat_q.sticky_saturation_flag)
    else $error("An operation cleared the sticky saturation flag.");

  a_none_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && ((op == aebx_pkg::OP_NONE)
    || ((op == aebx_pkg::OP_ACC_HALF) && !lo_en && !hi_en))
    |=> $stable(stat_q) && $stable(dest_q))
    else $error("An operation without an extraction touched flags or destination.");

  a_round_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    fire |=> $stable(stat_q.rounding_select))
    else $error("An operation changed the rounding select.");

  a_uint_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_UNSIGNED_INTEGER) && lo_en
    && acc0_q.ext[7]
    |=> (dest_q[15:0] == 16'h0000) && stat_q.saturation_flag && !stat_q.negative_flag)
    else $error("Negative value not clamped to zero by the unsigned integer option.");

  a_scaled_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_SCALED_INTEGER) && lo_en
    && (acc0_q.ext == 8'h00) && !acc0_q.word[31] && (acc0_q.word[30:14] != 17'h00000)
    |=> (dest_q[15:0] == 16'h7FFF) && stat_q.saturation_flag)
    else $error("Scaled integer overflow not clamped to the signed maximum.");

  a_round_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    fire && (op == aebx_pkg::OP_ACC_HALF) && (opt == aebx_pkg::OPT_DEFAULT) && lo_en
    && (acc0_q.ext == 8'h00) && (acc0_q.word[31:15] == 17'h0FFFF) && stat_q.rounding_select
    |=> (dest_q[15:0] == 16'h7FFF) && stat_q.saturation_flag)
    else $error("Rounding carry past the maximum was not saturated.");

endmodule // aebx_core

`default_nettype wire

// file: aebx_defs.svh
// Constants of the accumulator extract and byte extend datapath.
// Assumes inclusion by bare name from the testbench and the core.
`ifndef AEBX_DEFS_SVH
`define AEBX_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define AEBX_OFS_ACC0_WORD 8'h00
`define AEBX_OFS_ACC0_EXT 8'h04
`define AEBX_OFS_ACC1_WORD 8'h08
`define AEBX_OFS_ACC1_EXT 8'h0C
`define AEBX_OFS_SRC 8'h10
`define AEBX_OFS_DEST 8'h14
`define AEBX_OFS_STATUS 8'h18
`define AEBX_OFS_CMD 8'h1C

// ****************************************************************
// Field positions of the command word
// ****************************************************************
`define AEBX_CMD_OP_LSB 0
`define AEBX_CMD_OPT_LSB 4
`define AEBX_CMD_LO_BIT 8
`define AEBX_CMD_HI_BIT 9

// ****************************************************************
// Reset values and arithmetic constants
// ****************************************************************
`define AEBX_RST_WORD 32'h0000_0000
`define AEBX_RST_EXT 8'h00
`define AEBX_RST_STATUS 6'h00
`define AEBX_ROUND_HALF 42'sh000_0000_8000
`define AEBX_SMAX 42'sh000_0000_7FFF
`define AEBX_SMIN (-42'sh000_0000_8000)
`define AEBX_UMAX 42'sh000_0000_FFFF

`endif

// file: aebx_pkg.sv
// Types of the accumulator extract and byte extend datapath.
// Assumes the constants header is on the include path.
`default_nettype none

package aebx_pkg;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_ACC_HALF,
    OP_BYTE_ZEXT,
    OP_BYTE_SEXT
  } aebx_op_e;

  typedef enum logic [2:0] {
    OPT_DEFAULT,
    OPT_UNSIGNED_FRACTION,
    OPT_SIGNED_INTEGER,
    OPT_UNSIGNED_INTEGER,
    OPT_TRUNCATE,
    OPT_SCALED_ROUND,
    OPT_SCALED_INTEGER,
    OPT_HIGH_WORD_INTEGER
  } aebx_opt_e;

  // Bit order matches the status register, bit 0 first from the bottom.
  typedef struct packed {
    logic rounding_select;
    logic sticky_saturation_flag;
    logic saturation_flag;
    logic carry_flag;
    logic negative_flag;
    logic zero_result_flag;
  } aebx_status_s;

  typedef struct packed {
    logic [7:0] ext;
    logic [31:0] word;
  } aebx_acc_s;

endpackage

`default_nettype wire

// file: aebx_seq_model.sv
// Behavioural Wishbone classic master standing in for the instruction sequencer.
// Assumes one clock and a slave that answers every request with a single ack pulse.
`timescale 1ns/10ps
`default_nettype none

module aebx_seq_model (
  // Clock.
  input wire logic clk_i,
  // Wishbone master.
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'hFF;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h5A5A5A5A;
  end

  // Only one access is ever in flight, so a byte extension never shares a slot with another
  // operation.
  task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                        input logic [31:0] wdat, output logic [31:0] rdat);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= sel;
    wb_dat_o <= wdat;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    rdat = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    // Released address, select and data lines carry the inverse of the last value so a stale copy cannot pass.
    wb_adr_o <= ~adr;
    wb_sel_o <= ~sel;
    wb_dat_o <= ~wdat;
  endtask
endmodule // aebx_seq_model

`default_nettype wire
